// ---- inc/lock_status_pkg.sv ----
// Shared constants for the lock status pin block
package lock_status_pkg;

  // Unlock detection width select codes
  localparam logic [1:0] WIDTH_STOP   = 2'h0;
  localparam logic [1:0] WIDTH_DIRECT = 2'h1;
  localparam logic [1:0] WIDTH_NARROW = 2'h2;
  localparam logic [1:0] WIDTH_WIDE   = 2'h3;

  // Clock rate and detection widths
  localparam int CLK_MHZ          = 250;
  localparam int NARROW_WIDTH_NS  = 550;
  localparam int WIDE_WIDTH_NS    = 1100;
  localparam int NARROW_CYC       = (NARROW_WIDTH_NS * CLK_MHZ) / 1000;
  localparam int WIDE_CYC         = (WIDE_WIDTH_NS * CLK_MHZ) / 1000;
  // Stretch of the error indication (one to two reference periods)
  localparam int STRETCH_CYC      = 1024;
  localparam int CNT_W            = 16;

  // Status pin select codes
  localparam logic [2:0] SEL_OPEN      = 3'h0;
  localparam logic [2:0] SEL_UNLOCK    = 3'h1;
  localparam logic [2:0] SEL_COUNT_END = 3'h2;
  localparam logic [2:0] SEL_PORT1     = 3'h3;
  localparam logic [2:0] SEL_PORT2     = 3'h4;

  // Register word index
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;

  // Control register fields and reset
  localparam int CTRL_WIDTH_LO  = 0;
  localparam int CTRL_WIDTH_HI  = 1;
  localparam int CTRL_SEL_LSB   = 2;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Interrupt bits
  localparam int IRQ_UNLOCK    = 0;
  localparam int IRQ_COUNT_END = 1;

endpackage : lock_status_pkg

// ---- inc/unlock_if.sv ----
// Carrier between the status pin logic and the unlock detector
`timescale 1ns/1ps
interface unlock_if;
  logic [1:0] width_sel;
  logic       phase_err;
  logic       unlock_flag;
  logic       detect_en;
  modport ctrl (output width_sel, output phase_err, input unlock_flag, input detect_en);
  modport det  (input width_sel, input phase_err, output unlock_flag, output detect_en);
endinterface : unlock_if

// ---- rtl/lock_status_pin.sv ----
// Status pin control: unlock, count end, serial transfer and port override
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module lock_status_pin
  import lock_status_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        phase_err_i,
  input  wire logic        count_done_i,
  input  wire logic        bus_enable_i,
  input  wire logic        write_mode_one_i,
  input  wire logic        write_mode_two_i,
  input  wire logic        read_mode_i,
  input  wire logic        shift_clock_i,
  input  wire logic        serial_out_i,
  input  wire logic        port1_is_output_i,
  input  wire logic        port2_is_output_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  output logic             unlock_flag_o,
  output logic             status_pin_o,
  output logic             status_pin_oe_n_o
);

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        count_end;
    logic        unlock_flag;
    logic        bus_en_d;
    logic        shift_d;
    logic        pin_low;
    logic        pin_drive;
    logic [31:0] rdata;
  } pin_state_t;

  pin_state_t s;
  pin_state_t next_s;

  unlock_if det_link ();

  unlock_detect u_det (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .det        (det_link)
  );

  logic [1:0] width_sel;
  logic [2:0] pin_sel;
  logic       any_write;
  logic       transfer_end;
  logic [1:0] events;

  assign width_sel    = {s.ctrl[CTRL_WIDTH_HI], s.ctrl[CTRL_WIDTH_LO]};
  assign pin_sel      = s.ctrl[CTRL_SEL_LSB +: 3];
  assign det_link.width_sel = width_sel;
  assign det_link.phase_err = phase_err_i;
  assign any_write          = write_mode_one_i | write_mode_two_i;
  assign transfer_end       = s.bus_en_d & ~bus_enable_i;

  always_comb
  begin
    next_s          = s;
    next_s.rdata    = '0;
    // Mode drops together with bus enable, so the transfer kind is held here
    next_s.bus_en_d = bus_enable_i & (any_write | read_mode_i);
    next_s.shift_d  = shift_clock_i;
    next_s.unlock_flag = det_link.detect_en & det_link.unlock_flag;

    if (count_done_i)
      next_s.count_end = 1'b1;
    else if (transfer_end)
      next_s.count_end = 1'b0;

    events = {count_done_i & ~s.count_end, next_s.unlock_flag & ~s.unlock_flag};

    if (wr_i)
    begin
      case (addr_i)
        REG_CTRL:     next_s.ctrl     = wdata_i[4:0];
        REG_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~wdata_i[1:0];
        REG_IRQ_MASK: next_s.irq_mask = wdata_i[1:0];
        default:      next_s.ctrl     = s.ctrl;
      endcase
    end
    next_s.irq_stat = next_s.irq_stat | events;

    if (rd_i)
    begin
      case (addr_i)
        REG_CTRL:     next_s.rdata = {27'h0, s.ctrl};
        REG_STATUS:   next_s.rdata = {30'h0, s.count_end, s.unlock_flag};
        REG_IRQ_STAT: next_s.rdata = {30'h0, s.irq_stat};
        REG_IRQ_MASK: next_s.rdata = {30'h0, s.irq_mask};
        default:      next_s.rdata = '0;
      endcase
    end

    next_s.pin_drive = 1'b0;
    next_s.pin_low   = 1'b0;
    if (bus_enable_i && read_mode_i)
    begin
      // data shifted out on shift clock edge
      next_s.pin_drive = 1'b1;
      if (shift_clock_i && !s.shift_d)
        next_s.pin_low = ~serial_out_i;
      else
        next_s.pin_low = s.pin_low;
    end
    else if (bus_enable_i && any_write)
    begin
      next_s.pin_drive = 1'b0;
    end
    else
    begin
      case (pin_sel)
        SEL_UNLOCK:
        begin
          next_s.pin_drive = next_s.unlock_flag;
          next_s.pin_low   = next_s.unlock_flag;
        end
        SEL_COUNT_END:
        begin
          next_s.pin_drive = next_s.count_end;
          next_s.pin_low   = next_s.count_end;
        end
        SEL_PORT1:
        begin
          next_s.pin_drive = ~port1_is_output_i;
          next_s.pin_low   = 1'b0;
        end
        SEL_PORT2:
        begin
          next_s.pin_drive = ~port2_is_output_i;
          next_s.pin_low   = 1'b0;
        end
        default:
        begin
          next_s.pin_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s      <= '0;
      s.ctrl <= CTRL_RESET;
    end
    else if (ce_i)
      s <= next_s;
  end

  assign rdata_o           = s.rdata;
  assign irq_o             = |(s.irq_stat & s.irq_mask);
  assign unlock_flag_o     = s.unlock_flag;
  // Open drain: low level only, released otherwise
  assign status_pin_o      = ~s.pin_low;
  assign status_pin_oe_n_o = ~(s.pin_drive & s.pin_low);

endmodule : lock_status_pin

// ---- rtl/unlock_detect.sv ----
// Unlock detector: qualifies phase-error pulses by width and stretches them
`timescale 1ns/1ps
module unlock_detect
  import lock_status_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  unlock_if.det     det
);

  typedef struct packed {
    logic [CNT_W-1:0] width_cnt;
    logic [CNT_W-1:0] stretch_cnt;
    logic             flag;
  } det_state_t;

  det_state_t s;
  det_state_t next_s;

  function automatic logic [CNT_W-1:0] width_limit(input logic [1:0] sel);
    width_limit = (sel == WIDTH_NARROW) ? CNT_W'(NARROW_CYC) : CNT_W'(WIDE_CYC);
  endfunction : width_limit

  always_comb
  begin
    next_s = s;
    case (det.width_sel)
      WIDTH_STOP:
      begin
        next_s = '0;
      end
      WIDTH_DIRECT:
      begin
        next_s.width_cnt   = '0;
        next_s.stretch_cnt = '0;
        next_s.flag        = det.phase_err;
      end
      WIDTH_NARROW, WIDTH_WIDE:
      begin
        if (det.phase_err)
        begin
          if (s.width_cnt < width_limit(det.width_sel))
            next_s.width_cnt = s.width_cnt + CNT_W'(1);
          else
            next_s.stretch_cnt = CNT_W'(STRETCH_CYC);
        end
        else
        begin
          next_s.width_cnt = '0;
          if (s.stretch_cnt != '0)
            next_s.stretch_cnt = s.stretch_cnt - CNT_W'(1);
        end
        next_s.flag = (next_s.stretch_cnt != '0);
      end
      default:
      begin
        next_s = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else if (ce_i)
      s <= next_s;
  end

  assign det.unlock_flag = s.flag;
  assign det.detect_en   = (det.width_sel != WIDTH_STOP);

endmodule : unlock_detect

// ---- verification/lock_status_checker.sv ----
// Port checker for the lock status pin block
`timescale 1ns/1ps
module lock_status_checker
  import lock_status_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        phase_err_i,
  input wire logic        count_done_i,
  input wire logic        bus_enable_i,
  input wire logic        write_mode_one_i,
  input wire logic        read_mode_i,
  input wire logic        shift_clock_i,
  input wire logic        serial_out_i,
  input wire logic        port1_is_output_i,
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        unlock_flag_o,
  input wire logic        status_pin_oe_n_o
);
  logic [4:0] ctrl;
  wire  [2:0] sel = ctrl[4:2];
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
      ctrl <= CTRL_RESET;
    else if (wr_i && addr_i == REG_CTRL)
      ctrl <= wdata_i[4:0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_direct_unlock:
    assert property ((ctrl == {SEL_UNLOCK, WIDTH_DIRECT} && phase_err_i && !bus_enable_i)[*4]
      |-> !status_pin_oe_n_o && unlock_flag_o) else $error("unlock not on pin");
  a_direct_release:
    assert property ((ctrl == {SEL_UNLOCK, WIDTH_DIRECT} && !phase_err_i && !bus_enable_i)[*4]
      |-> status_pin_oe_n_o) else $error("pin held after error ends");
  a_stop_open:
    assert property ((ctrl == {SEL_UNLOCK, WIDTH_STOP} && !bus_enable_i)[*3]
      |-> status_pin_oe_n_o) else $error("stopped detector drives pin");
  a_write_open:
    assert property ((bus_enable_i && write_mode_one_i)[*2] |-> status_pin_oe_n_o)
      else $error("pin driven in write transfer");
  a_read_low:
    assert property (bus_enable_i && read_mode_i && $rose(shift_clock_i) && !serial_out_i
      ##1 (bus_enable_i && read_mode_i && !serial_out_i)[*3] |-> !status_pin_oe_n_o)
      else $error("read bit not on pin");
  a_port_open:
    assert property ((sel == SEL_PORT1 && port1_is_output_i && !bus_enable_i)[*2]
      |-> status_pin_oe_n_o) else $error("pin driven under port use");
  a_count_low:
    assert property (sel == SEL_COUNT_END && count_done_i && !bus_enable_i
      |-> ##[1:2] !status_pin_oe_n_o) else $error("count end not shown");
  a_count_reopen:
    assert property (sel == SEL_COUNT_END && $fell(bus_enable_i) |-> ##[1:2] status_pin_oe_n_o)
      else $error("pin not reopened");
endmodule : lock_status_checker
bind lock_status_pin lock_status_checker chk (.core_clk_i, .rst_i, .phase_err_i, .count_done_i,
  .bus_enable_i, .write_mode_one_i, .read_mode_i, .shift_clock_i, .serial_out_i,
  .port1_is_output_i, .addr_i, .wdata_i, .wr_i, .unlock_flag_o, .status_pin_oe_n_o);

// ---- verification/lock_status_pin_tb_top.sv ----
// Self-checking bench for the lock status pin block
`timescale 1ns/1ps
module lock_status_pin_tb_top;
  import lock_status_pkg::*;
  logic        core_clk_i = 0, rst_i = 1, perr = 0, cdone = 0, p1 = 0, p2 = 0;
  logic        wr = 0, rd = 0, irq, flag, pin, oe_n, en, sck, so;
  logic [3:0]  addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [2:0]  mode;
  int          fail_count = 0, checked = 0;
  initial forever #2 core_clk_i = ~core_clk_i;
  serial_host host (.clk_i(core_clk_i), .bus_enable_o(en), .mode_o(mode), .shift_clock_o(sck),
    .serial_out_o(so));
  lock_status_pin uut (.core_clk_i, .rst_i, .ce_i(1'b1), .phase_err_i(perr),
    .count_done_i(cdone), .bus_enable_i(en), .write_mode_one_i(mode[2]),
    .write_mode_two_i(mode[1]), .read_mode_i(mode[0]), .shift_clock_i(sck), .serial_out_i(so),
    .port1_is_output_i(p1), .port2_is_output_i(p2), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .unlock_flag_o(flag), .status_pin_o(pin),
    .status_pin_oe_n_o(oe_n));
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    chk("rdata", rdata, exp);
  endtask : rreg
  task automatic setc(input logic [2:0] s, input logic [1:0] w);
    wreg(REG_CTRL, {27'h0, s, w});
  endtask : setc
  task automatic t_direct;
    wreg(REG_IRQ_MASK, 32'h3);
    setc(SEL_UNLOCK, WIDTH_DIRECT);
    perr <= 1'b1;
    cyc(4);
    chk("pin_oe_n", oe_n, 0);
    chk("pin", pin, 0);
    chk("flag", flag, 1);
    chk("irq", irq, 1);
    rreg(REG_STATUS, 32'h1);
    perr <= 1'b0;
    cyc(4);
    chk("pin_oe_n", oe_n, 1);
    chk("pin", pin, 1);
    wreg(REG_IRQ_MASK, 32'h0);
    cyc(0);
    chk("irq", irq, 0);
    wreg(REG_IRQ_STAT, 32'h3);
    rreg(REG_IRQ_STAT, 32'h0);
  endtask : t_direct
  task automatic t_width(input logic [1:0] w, input int len, input logic exp);
    setc(SEL_UNLOCK, w);
    perr <= 1'b1;
    cyc(len);
    perr <= 1'b0;
    cyc(3);
    chk("flag", flag, exp);
    cyc(500);
    chk("flag", flag, exp);
    cyc(2100);
    chk("flag", flag, 0);
  endtask : t_width
  task automatic t_xfer;
    logic [2:0] k[4] = '{3'h4, 3'h2, 3'h1, 3'h1};
    setc(SEL_UNLOCK, WIDTH_STOP);
    perr <= 1'b1;
    cyc(5);
    chk("pin_oe_n", oe_n, 1);
    setc(SEL_UNLOCK, WIDTH_DIRECT);
    for (int i = 0; i < 4; i++)
    begin
      host.start(k[i], i[0]);
      cyc(0);
      chk("pin_oe_n", oe_n, {31'h0, i != 2});
      host.stop;
    end
    perr <= 1'b0;
  endtask : t_xfer
  task automatic t_count;
    wreg(REG_IRQ_STAT, 32'h3);
    wreg(REG_IRQ_MASK, 32'h3);
    setc(SEL_COUNT_END, WIDTH_STOP);
    cdone <= 1'b1;
    cyc(1);
    cdone <= 1'b0;
    cyc(2);
    chk("pin_oe_n", oe_n, 0);
    chk("irq", irq, 1);
    rreg(REG_STATUS, 32'h2);
    host.start(3'h1, 1'b1);
    host.stop;
    cyc(2);
    chk("pin_oe_n", oe_n, 1);
    cdone <= 1'b1;
    cyc(1);
    cdone <= 1'b0;
    chk("pin_oe_n", oe_n, 0);
    p1 <= 1'b1;
    p2 <= 1'b1;
    setc(SEL_PORT1, WIDTH_STOP);
    cyc(2);
    chk("pin_oe_n", oe_n, 1);
    setc(SEL_PORT2, WIDTH_STOP);
    cyc(2);
    chk("pin_oe_n", oe_n, 1);
  endtask : t_count
  task automatic test_done;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  initial
  begin
    cyc(4);
    rst_i <= 1'b0;
    rreg(REG_CTRL, {27'h0, CTRL_RESET});
    rreg(4'hF, 32'h0);
    t_direct;
    t_width(WIDTH_NARROW, NARROW_CYC - 10, 0);
    t_width(WIDTH_NARROW, NARROW_CYC + 10, 1);
    t_width(WIDTH_WIDE, WIDE_CYC - 10, 0);
    t_width(WIDTH_WIDE, WIDE_CYC + 10, 1);
    t_xfer;
    t_count;
    test_done;
  end
  initial
  begin
    #200000;
    fail_count++;
    test_done;
  end
endmodule : lock_status_pin_tb_top

// ---- verification/serial_host.sv ----
// Host model for the three-wire serial transfer side
`timescale 1ns/1ps
module serial_host
(
  input  wire logic       clk_i,
  output logic            bus_enable_o,
  output logic [2:0]      mode_o,
  output logic            shift_clock_o,
  output logic            serial_out_o
);
  initial {bus_enable_o, mode_o, shift_clock_o, serial_out_o} = 6'h00;
  task automatic start(input logic [2:0] kind, input logic bit_val);
    @(posedge clk_i);
    mode_o <= kind;
    bus_enable_o <= 1'b1;
    serial_out_o <= bit_val;
    repeat (2) @(posedge clk_i);
    shift_clock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : start
  // Shift clock stands low outside frames
  task automatic stop;
    bus_enable_o <= 1'b0;
    shift_clock_o <= 1'b0;
    mode_o <= 3'h0;
    serial_out_o <= ~serial_out_o;
    @(posedge clk_i);
  endtask : stop
endmodule : serial_host
